/* File: pkg/fbpwm_pkg.sv */
package fbpwm_pkg;

    // ------------------------------------------------------------------
    // Register map (word byte addresses)
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL   = 4'h0;
    localparam logic [3:0] ADDR_DUTY      = 4'h4;
    localparam logic [3:0] ADDR_PERIOD    = 4'h8;
    localparam logic [3:0] ADDR_DIRECTION = 4'hC;
    localparam int         ADDR_W         = 4;
    localparam int         DATA_W         = 32;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_CFG_HI   = 7;
    localparam int CTRL_CFG_LO   = 6;
    localparam int CTRL_LSB_HI   = 5;
    localparam int CTRL_LSB_LO   = 4;
    localparam int CTRL_MODE_HI  = 3;
    localparam int CTRL_MODE_LO  = 0;

    localparam logic [1:0] CFG_SINGLE  = 2'h0;
    localparam logic [1:0] CFG_FWD     = 2'h1;
    localparam logic [1:0] CFG_HALF    = 2'h2;
    localparam logic [1:0] CFG_REV     = 2'h3;

    // Mode bits 3:2 = 11 selects PWM; bits 1:0 select polarity of A/C and B/D.
    localparam logic [1:0] MODE_PWM    = 2'h3;
    localparam int         POL_AC_BIT  = 1;
    localparam int         POL_BD_BIT  = 0;

    localparam logic [7:0] CONTROL_RST   = 8'h00;
    localparam logic [7:0] DUTY_RST      = 8'h00;
    localparam logic [7:0] PERIOD_RST    = 8'hFF;
    localparam logic [3:0] DIRECTION_RST = 4'hF;
    localparam int         DUTY_W        = 10;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } fbpwm_bus_t;

    // Four bridge pins, index 0..3 = A..D.
    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } fbpwm_pins_t;

endpackage

/* File: design/fbpwm_timebase.sv */
`timescale 1ns/100ps
module fbpwm_timebase
    import fbpwm_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic [7:0]        period_i,
    input  wire logic [DUTY_W-1:0] duty_i,
    output logic                   pwm_o,
    output logic                   cycle_start_o
);

    // ------------------------------------------------------------------
    // Ten-bit counter: period register plus two fine bits.
    // ------------------------------------------------------------------
    logic [DUTY_W-1:0] cnt_reg;
    logic [DUTY_W-1:0] duty_reg;
    logic              wrap;

    assign wrap          = (cnt_reg == {period_i, 2'h3});
    assign cycle_start_o = wrap;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_reg <= '0;
        end else if (wrap) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 10'h001;
        end
    end

    // Duty is latched at period end so a write never makes a glitch pulse.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            duty_reg <= '0;
        end else if (wrap) begin
            duty_reg <= duty_i;
        end
    end

    // High time grows linearly with the duty value.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pwm_o <= 1'b0;
        end else begin
            pwm_o <= wrap ? (duty_i != '0) : ((cnt_reg + 10'h001) < duty_reg);
        end
    end

endmodule

/* File: design/fbpwm_steer.sv */
`timescale 1ns/100ps
module fbpwm_steer
    import fbpwm_pkg::*;
(
    input  wire logic [1:0] cfg_i,
    input  wire logic [3:0] mode_i,
    input  wire logic [3:0] dir_in_i,
    input  wire logic       pwm_i,
    output fbpwm_pins_t     pins_o
);

    logic pol_ac;
    logic pol_bd;
    logic pwm_on;
    logic [3:0] lvl;
    logic [3:0] want;

    assign pwm_on = (mode_i[3:2] == MODE_PWM);
    assign pol_ac = mode_i[POL_AC_BIT];
    assign pol_bd = mode_i[POL_BD_BIT];

    always_comb begin
        lvl  = 4'h0;
        want = 4'h0;
        if (pwm_on) begin
            unique case (cfg_i)
                CFG_FWD: begin
                    lvl  = {pwm_i, 1'b0, 1'b0, 1'b1};
                    want = 4'b1001;
                end
                CFG_REV: begin
                    lvl  = {1'b0, 1'b1, pwm_i, 1'b0};
                    want = 4'b0110;
                end
                CFG_HALF: begin
                    lvl  = {2'b00, ~pwm_i, pwm_i};
                    want = 4'b0011;
                end
                CFG_SINGLE: begin
                    lvl  = {3'b000, pwm_i};
                    want = 4'b0001;
                end
            endcase
        end
    end

    assign pins_o.out = lvl ^ {pol_bd, pol_ac, pol_bd, pol_ac};
    assign pins_o.oe  = want & ~dir_in_i;

endmodule

/* File: design/fbpwm_top.sv */
`timescale 1ns/100ps
// Functional notes
// - Forward full bridge holds A high, modulates D, leaves B and C undriven.
// - Reverse full bridge holds C high, modulates B, leaves A and D undriven.
// - An undriven bridge output is a pin set as input, its enable low.
// - Control bits 7:6 pick the output setup; pins C and D are unit outputs only in bridge modes.
// - Control bits 3:0 pick PWM mode and polarity; the motor setting is all active high.
// - The modulated high time rises in proportion to the ten-bit duty value.
// - A pin marked input by the direction register shows no waveform while the PWM runs on.
// - Duty has ten bits: the duty register above control bits 5:4.
// - The A/C pair and the B/D pair each choose active high or low on their own.
module fbpwm_top
    import fbpwm_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    output logic      [3:0]        bridge_out_o,
    output logic      [3:0]        bridge_oe_o,
    output logic                   pwm_level_o
);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    fbpwm_bus_t  bus;
    logic [7:0]  pwm_unit_control_reg;
    logic [7:0]  duty_upper_byte_reg;
    logic [7:0]  period_reg;
    logic [3:0]  pin_direction_reg;
    logic [DUTY_W-1:0] duty;
    logic        pwm;
    logic        cycle_start;
    fbpwm_pins_t pins;

    assign bus = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pwm_unit_control_reg <= CONTROL_RST;
        end else if (bus.wr && bus.addr == ADDR_CONTROL) begin
            pwm_unit_control_reg <= bus.wdata[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            duty_upper_byte_reg <= DUTY_RST;
        end else if (bus.wr && bus.addr == ADDR_DUTY) begin
            duty_upper_byte_reg <= bus.wdata[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            period_reg <= PERIOD_RST;
        end else if (bus.wr && bus.addr == ADDR_PERIOD) begin
            period_reg <= bus.wdata[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_direction_reg <= DIRECTION_RST;
        end else if (bus.wr && bus.addr == ADDR_DIRECTION) begin
            pin_direction_reg <= bus.wdata[3:0];
        end
    end

    // Read data stand one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= '0;
        end else if (bus.rd) begin
            unique case (bus.addr)
                ADDR_CONTROL:   rdata_o <= {24'h000000, pwm_unit_control_reg};
                ADDR_DUTY:      rdata_o <= {24'h000000, duty_upper_byte_reg};
                ADDR_PERIOD:    rdata_o <= {24'h000000, period_reg};
                ADDR_DIRECTION: rdata_o <= {27'h0000000, pwm, pin_direction_reg};
                default:        rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end

    // ------------------------------------------------------------------
    // PWM and steering
    // ------------------------------------------------------------------
    // ten-bit duty
    assign duty = {duty_upper_byte_reg, pwm_unit_control_reg[CTRL_LSB_HI:CTRL_LSB_LO]};

    fbpwm_timebase u_timebase (
        .clk_i         (clk_i),
        .sys_rst_i     (sys_rst_i),
        .period_i      (period_reg),
        .duty_i        (duty),
        .pwm_o         (pwm),
        .cycle_start_o (cycle_start)
    );

    fbpwm_steer u_steer (
        .cfg_i    (pwm_unit_control_reg[CTRL_CFG_HI:CTRL_CFG_LO]),
        .mode_i   (pwm_unit_control_reg[CTRL_MODE_HI:CTRL_MODE_LO]),
        .dir_in_i (pin_direction_reg),
        .pwm_i    (pwm),
        .pins_o   (pins)
    );

    assign bridge_out_o = pins.out;
    assign bridge_oe_o  = pins.oe;
    assign pwm_level_o  = pwm;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic fwd_active;
    logic rev_active;
    logic all_hi;
    assign all_hi     = pwm_unit_control_reg[CTRL_MODE_HI:CTRL_MODE_LO] == 4'hC;
    assign fwd_active = all_hi && pwm_unit_control_reg[CTRL_CFG_HI:CTRL_CFG_LO] == CFG_FWD;
    assign rev_active = all_hi && pwm_unit_control_reg[CTRL_CFG_HI:CTRL_CFG_LO] == CFG_REV;

    a_fwd_a_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        fwd_active && !pin_direction_reg[0] |-> bridge_out_o[0] && bridge_oe_o[0])
        else $error("forward: output A not held high");

    a_fwd_d_mod: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        fwd_active && !pin_direction_reg[3] |-> bridge_out_o[3] == pwm && bridge_oe_o[3])
        else $error("forward: output D not modulated");

    a_fwd_bc_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        fwd_active |-> bridge_oe_o[2:1] == 2'b00)
        else $error("forward: B or C driven");

    a_rev_c_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rev_active && !pin_direction_reg[2] |-> bridge_out_o[2] && bridge_oe_o[2]
        && bridge_out_o[1] == pwm && bridge_oe_o[0] == 1'b0 && bridge_oe_o[3] == 1'b0)
        else $error("reverse: steering wrong");

    a_non_bridge_cd: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        pwm_unit_control_reg[CTRL_CFG_LO] == 1'b0 |-> bridge_oe_o[3:2] == 2'b00)
        else $error("C or D driven outside bridge modes");

    a_dir_gates_pin: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (bridge_oe_o & pin_direction_reg) == 4'h0)
        else $error("pin marked input is driven");

    a_pol_invert: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        pwm_unit_control_reg[3:0] == 4'hD && fwd_active == 1'b0
        && pwm_unit_control_reg[7:6] == CFG_FWD |-> bridge_out_o[3] == ~pwm)
        else $error("B/D polarity not inverted");

    a_zero_duty: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cycle_start && duty == '0 |=> !pwm)
        else $error("zero duty gives high time");

    a_duty_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cycle_start && duty == 10'h001 && $stable(duty) |=> pwm ##1 !pwm)
        else $error("one-count duty wrong width");

    c_forward: cover property (@(posedge clk_i) fwd_active && bridge_out_o[3]);
    c_reverse: cover property (@(posedge clk_i) rev_active && bridge_out_o[1]);
    c_gated:   cover property (@(posedge clk_i) fwd_active && pin_direction_reg[3] && pwm);

endmodule

/* File: sim/fbpwm_bridge_model.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Gate driver stage of the external full bridge
// ------------------------------------------------------------------
module fbpwm_bridge_model
(
    input  wire logic [3:0] pin_out_i,
    input  wire logic [3:0] pin_oe_i,
    output logic      [3:0] gate_on_o,
    output logic            shoot_o
);
    // A driver input left floating sits on its pull-down, so its gate stays off.
    // undriven gate off
    assign gate_on_o = pin_out_i & pin_oe_i;
    // Both switches of one leg on at once would short the supply.
    assign shoot_o   = (gate_on_o[0] & gate_on_o[1]) | (gate_on_o[2] & gate_on_o[3]);
endmodule

/* File: sim/tb_full_bridge_pwm_steering.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module tb_full_bridge_pwm_steering
    import fbpwm_pkg::*;
;
    logic              clk_i     = 1'b0;
    logic              sys_rst_i = 1'b1;
    logic [ADDR_W-1:0] addr_i    = '0;
    logic [DATA_W-1:0] wdata_i   = '0;
    logic              wr_i      = 1'b0;
    logic              rd_i      = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic [3:0]        bridge_out_o;
    logic [3:0]        bridge_oe_o;
    logic              pwm_level_o;
    logic [3:0]        gate_on;
    logic              shoot;
    logic              rd_d      = 1'b0;
    logic              smp       = 1'b0;
    logic [7:0]        cnt       = 8'h00;
    logic [63:0]       q[$];
    logic [63:0]       note;
    logic [31:0]       obs;
    int                num_errors = 0;
    int                checks     = 0;

    fbpwm_top uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .bridge_out_o(bridge_out_o),
        .bridge_oe_o(bridge_oe_o), .pwm_level_o(pwm_level_o));
    fbpwm_bridge_model far (.pin_out_i(bridge_out_o), .pin_oe_i(bridge_oe_o),
        .gate_on_o(gate_on), .shoot_o(shoot));

    assign obs = {15'h0000, cnt, shoot, gate_on, bridge_oe_o};

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------------
    // Result monitor
    // ------------------------------------------------------------------
    always @(posedge clk_i) rd_d <= rd_i;
    always @(negedge clk_i) begin
        if (rd_d || smp) begin
            note = q.pop_front();
            `CHK((rd_d ? rdata_o : obs) & note[63:32], note[31:0])
        end
    end

    // ------------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= {24'h000000, d};
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        q.push_back({32'hFFFFFFFF, 24'h000000, e});
        @(posedge clk_i);
        rd_i   <= 1'b0;
    endtask

    task automatic sample(input logic [31:0] m, input logic [31:0] e);
        @(posedge clk_i);
        smp <= 1'b1;
        q.push_back({m, e});
        @(posedge clk_i);
        smp <= 1'b0;
    endtask

    task automatic count_high();
        logic [7:0] n;
        n = 8'h00;
        repeat (16) begin
            @(negedge clk_i);
            n = n + 8'(pwm_level_o === 1'b1);
        end
        cnt = n;
    endtask

    function automatic logic [8:0] exp_pins(input logic [1:0] cfg, input logic [3:0] md,
                                            input logic [3:0] dir, input logic p);
        logic [3:0] oe;
        logic [3:0] o;
        oe = 4'h0;
        o  = 4'h0;
        if (md[3:2] == MODE_PWM && cfg == CFG_FWD) begin
            oe = 4'h9;
            o  = {p ^ md[POL_BD_BIT], 2'b00, ~md[POL_AC_BIT]};
        end
        if (md[3:2] == MODE_PWM && cfg == CFG_REV) begin
            oe = 4'h6;
            o  = {1'b0, ~md[POL_AC_BIT], p ^ md[POL_BD_BIT], 1'b0};
        end
        oe = oe & ~dir;
        return {1'b0, o & oe, oe};
    endfunction

    task automatic report_and_stop();
        if (num_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [1:0] cfg;
        logic [3:0] md;
        logic [3:0] dir;
        logic       p;
        void'($urandom(56));
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(ADDR_CONTROL, CONTROL_RST);
        rd(ADDR_DUTY, DUTY_RST);
        rd(ADDR_PERIOD, PERIOD_RST);
        rd(ADDR_DIRECTION, {4'h0, DIRECTION_RST});
        rd(4'h2, 8'h00);
        sample(32'h1FF, 32'h000);
        // Short period so a duty of zero or full scale gives a steady level.
        wr(ADDR_PERIOD, 8'h00);
        // The counter already stands past the new end, so it runs through its overflow first.
        repeat (1030) @(posedge clk_i);
        for (int i = 0; i < 32; i++) begin
            cfg = i[3:2];
            md  = {2'b11, i[1:0]};
            if (i >= 16) md[3:2] = 2'($urandom);
            dir = i[0] ? 4'($urandom) : 4'h0;
            p   = 1'($urandom);
            wr(ADDR_CONTROL, {cfg, 2'b00, md});
            wr(ADDR_DUTY, p ? 8'hFF : 8'h00);
            wr(ADDR_DIRECTION, {4'h0, dir});
            repeat (12) @(posedge clk_i);
            sample((!cfg[0] && md[3:2] == MODE_PWM) ? 32'h0CC : 32'h1FF,
                   {23'h0, exp_pins(cfg, md, dir, p)});
            rd(ADDR_DIRECTION, {3'h0, p, dir});
        end
        // Outside pin control coasts the motor by releasing every output.
        wr(ADDR_CONTROL, 8'h4C);
        wr(ADDR_DIRECTION, 8'h0F);
        wr(ADDR_DUTY, 8'hFF);
        repeat (4) @(posedge clk_i);
        sample(32'h1FF, 32'h000);
        rd(ADDR_DIRECTION, 8'h1F);
        wr(ADDR_PERIOD, 8'h01);
        wr(ADDR_DIRECTION, 8'h00);
        for (int d = 0; d <= 8; d++) begin
            wr(ADDR_CONTROL, {2'b01, d[1:0], 4'hC});
            wr(ADDR_DUTY, 8'(d >> 2));
            repeat (24) @(posedge clk_i);
            count_high();
            sample(32'h1FE00, 32'(2 * d) << 9);
            rd(ADDR_CONTROL, {2'b01, d[1:0], 4'hC});
        end
        repeat (2) @(posedge clk_i);
        if (q.size() != 0) num_errors++;
        report_and_stop();
    end
endmodule
